// file: src/prc_deglitch.sv
`timescale 1ns/1ps
// passes a synchronised level only after it has held for STABLE_CYC cycles
module prc_deglitch #(
    parameter int STABLE_CYC = prc_pkg::DEGLITCH_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_level,
    output logic o_level
);
    localparam int CW = $clog2(STABLE_CYC + 1);

    if (STABLE_CYC < 1) begin : g_bad
        $error("prc_deglitch: STABLE_CYC must be at least one");
    end

    logic level_reg, level_next;
    logic [CW-1:0] cnt_reg, cnt_next;

    // count cycles of disagreement; any return to the old level restarts the count
    always_comb begin
        level_next = level_reg;
        cnt_next = cnt_reg;
        if (i_level == level_reg) begin
            cnt_next = '0;
        end else if (cnt_reg == CW'(STABLE_CYC - 1)) begin
            level_next = i_level;
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + CW'(1);
        end
    end

    // low after reset: treat the pin as asserted until proven otherwise
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            level_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            level_reg <= level_next;
            cnt_reg <= cnt_next;
        end
    end

    assign o_level = level_reg;

    glitch_reject_a: assert property ( // [R5]
        @(posedge i_clk) disable iff (i_sys_rst)
        (level_reg != $past(level_reg)) |-> ($past(cnt_reg) == CW'(STABLE_CYC - 1)))
        else $error("deglitch output moved before the stable time");

    glitch_restart_a: assert property ( // [R5]
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_level == level_reg) |=> (cnt_reg == '0))
        else $error("deglitch count not cleared by a returning level");
endmodule // prc_deglitch

// file: src/prc_pkg.sv
// How it works
// R1 - MAC-side outputs forced low whenever the transceiver core sits in reset.
// R2 - at power-up stay in hardware reset until power-good is seen.
// R3 - a supply dropping re-enters hardware reset until power is good again.
// R4 - the outside controller holds the reset pin low for at least 10 us.
// R5 - reset pin low pulses shorter than about 1 us are rejected.
// R6 - after reset release pins stay tristated, straps latch, then pins go functional.
// R7 - oscillator enables first, PLL only after the crystal settling time.
// R8 - internal logic and registers released within 50 ms of pin release.
// R9 - chip soft reset bit starts the full start-up sequence again.
// R10 - after chip soft reset, logic and registers return within 10 ms.
// R11 - system ready flag sets once start-up has completed.
// R12 - core reset bit resets core logic about 1.2 us then self-clears.
// R13 - core reset keeps register contents and register access.
// R14 - host port reset bit resets MAC interface about 1.2 us, self-clears.
// R15 - host port reset aborts transfers, keeps link, keeps registers accessible.
// R16 - interrupt pin low on link change or FIFO error when enabled.
// R17 - hardware reset interrupt cannot be masked.
// R18 - each maskable cause passes both system mask and core mask.
// R19 - host reads both flag registers to find the interrupt cause.
// R20 - indicator pin pulled to supply at reset selects active-low drive.
// R21 - straps sampled two-level at reset exit and held as register defaults.
// R22 - ready flag reads zero from any full reset until start-up completes.
// R23 - reset request bits read zero once their action is complete.
package prc_pkg;
    // clock rate and time figures
    localparam int CLK_MHZ = 125;
    localparam int DEGLITCH_NS = 1000;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_NS = 1200;
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ) / 1000;
    localparam int TRISTATE_NS = 1000;
    localparam int TRISTATE_CYC = (TRISTATE_NS * CLK_MHZ + 999) / 1000;
    localparam int XTAL_US = 2000;
    localparam int XTAL_CYC = XTAL_US * CLK_MHZ;
    localparam int PLL_US = 1000;
    localparam int PLL_CYC = PLL_US * CLK_MHZ;
    localparam int HW_RELEASE_MS = 50;
    localparam int HW_RELEASE_CYC = HW_RELEASE_MS * 1000 * CLK_MHZ;
    localparam int SW_RELEASE_MS = 10;
    localparam int SW_RELEASE_CYC = SW_RELEASE_MS * 1000 * CLK_MHZ;

    // register map, device 0x1E
    localparam logic [4:0] DEV_ADDR = 5'h1E;
    localparam logic [15:0] OFS_CHIP_RST = 16'h8810;
    localparam logic [15:0] OFS_CORE_RST = 16'h8814;
    localparam logic [15:0] OFS_PORT_RST = 16'h8815;
    localparam logic [15:0] OFS_SYS_STATE = 16'h8818;
    localparam logic [15:0] OFS_SYS_IRQ_MASK = 16'h8820;
    localparam logic [15:0] OFS_CORE_IRQ_MASK = 16'h8821;
    localparam logic [15:0] OFS_SYS_IRQ_FLAGS = 16'h8822;
    localparam logic [15:0] OFS_CORE_IRQ_FLAGS = 16'h8823;

    // field positions
    localparam int RST_BIT = 0;
    localparam int READY_BIT = 0;
    localparam int SYS_HWRST_BIT = 0;
    localparam int SYS_CORE_BIT = 1;
    localparam int CORE_LINK_BIT = 0;
    localparam int CORE_FIFO_BIT = 1;

    // values after reset
    localparam logic [15:0] SYS_MASK_RST = 16'h0000;
    localparam logic [15:0] CORE_MASK_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_HWRST,
        ST_TRIST,
        ST_STRAP,
        ST_OSC,
        ST_PLL,
        ST_RUN
    } prc_seq_t;
endpackage

// file: src/prc_pulse_timer.sv
`timescale 1ns/1ps
// one start pulse gives a level of exactly PULSE_CYC cycles; starts while busy are dropped
module prc_pulse_timer #(
    parameter int PULSE_CYC = prc_pkg::PULSE_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    output logic o_active
);
    localparam int CW = $clog2(PULSE_CYC + 1);

    if (PULSE_CYC < 1) begin : g_bad
        $error("prc_pulse_timer: PULSE_CYC must be at least one");
    end

    logic active_reg, active_next;
    logic [CW-1:0] cnt_reg, cnt_next;

    // self-clearing: the level ends on its own, software never clears it
    always_comb begin
        active_next = active_reg;
        cnt_next = cnt_reg;
        if (active_reg) begin
            if (cnt_reg == CW'(PULSE_CYC - 1)) begin
                active_next = 1'b0;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end else if (i_start) begin
            active_next = 1'b1;
            cnt_next = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            active_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            active_reg <= active_next;
            cnt_reg <= cnt_next;
        end
    end

    assign o_active = active_reg;

    pulse_length_a: assert property ( // [R12]
        @(posedge i_clk) disable iff (i_sys_rst)
        $fell(active_reg) |-> ($past(cnt_reg) == CW'(PULSE_CYC - 1)))
        else $error("reset pulse ended at the wrong length");

    pulse_start_a: assert property ( // [R14]
        @(posedge i_clk) disable iff (i_sys_rst)
        (!active_reg && i_start) |=> (active_reg && cnt_reg == '0))
        else $error("reset pulse did not start on request");
endmodule // prc_pulse_timer

// file: src/prc_top.sv
`timescale 1ns/1ps
// reset sequencing, soft resets and interrupt gating behind the management register port
module prc_top #(
    parameter int STRAP_W = 6,
    parameter int MAC_W = 8,
    parameter int XTAL_CYC = prc_pkg::XTAL_CYC,
    parameter int PLL_CYC = prc_pkg::PLL_CYC,
    parameter int HW_RELEASE_CYC = prc_pkg::HW_RELEASE_CYC,
    parameter int SW_RELEASE_CYC = prc_pkg::SW_RELEASE_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_reset_pin_n,
    input wire logic i_power_good,
    input wire logic [STRAP_W-1:0] i_strap,
    input wire logic i_ind_a_sense,
    input wire logic i_ind_b_sense,
    input wire logic [MAC_W-1:0] i_mac_out,
    input wire logic i_link_change,
    input wire logic i_fifo_error,
    input wire logic [4:0] i_reg_dev,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic [MAC_W-1:0] o_mac_out,
    output logic o_io_functional,
    output logic o_osc_en,
    output logic o_pll_en,
    output logic o_logic_rst,
    output logic o_core_rst,
    output logic o_host_port_rst,
    output logic o_system_ready,
    output logic [STRAP_W-1:0] o_strap_latched,
    output logic o_ind_a_active_low,
    output logic o_ind_b_active_low,
    output logic o_int_n
);
    localparam int SYNC_W = STRAP_W + 4;
    localparam int SEQ_CYC = prc_pkg::TRISTATE_CYC + XTAL_CYC + PLL_CYC + 2;

    if (XTAL_CYC < 1 || PLL_CYC < 1 || STRAP_W < 1 || MAC_W < 1
            || SEQ_CYC >= SW_RELEASE_CYC || SW_RELEASE_CYC > HW_RELEASE_CYC) begin : g_bad
        $error("prc_top: start-up counts do not fit the release windows");
    end

    // two-flop synchronisers for every pin-level input
    logic [SYNC_W-1:0] async_in, sync1_reg, sync2_reg;
    assign async_in = {i_ind_b_sense, i_ind_a_sense, i_strap, i_power_good, i_reset_pin_n};
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic pin_clean, pg_s, hw_req;
    assign pg_s = sync2_reg[1];

    prc_deglitch #(.STABLE_CYC(prc_pkg::DEGLITCH_CYC)) u_pin_filter (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_level(sync2_reg[0]),
        .o_level(pin_clean)
    ); // [R5]

    // a filtered low pin or any bad supply holds the chip in hardware reset
    assign hw_req = !pg_s || !pin_clean; // [R2] [R3]

    // register port decode; writes only land once the logic is released
    prc_pkg::prc_seq_t state_reg, state_next;
    logic wr_hit, rd_hit, chip_rst_wr, core_start, port_start;
    assign wr_hit = i_reg_wr && i_reg_dev == prc_pkg::DEV_ADDR && state_reg == prc_pkg::ST_RUN;
    assign rd_hit = i_reg_rd && i_reg_dev == prc_pkg::DEV_ADDR && state_reg == prc_pkg::ST_RUN;
    assign chip_rst_wr = wr_hit && i_reg_addr == prc_pkg::OFS_CHIP_RST
        && i_reg_wdata[prc_pkg::RST_BIT]; // [R9]
    assign core_start = wr_hit && i_reg_addr == prc_pkg::OFS_CORE_RST
        && i_reg_wdata[prc_pkg::RST_BIT];
    assign port_start = wr_hit && i_reg_addr == prc_pkg::OFS_PORT_RST
        && i_reg_wdata[prc_pkg::RST_BIT];

    logic core_active, port_active;
    prc_pulse_timer #(.PULSE_CYC(prc_pkg::PULSE_CYC)) u_core_pulse (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(core_start),
        .o_active(core_active)
    ); // [R12]
    prc_pulse_timer #(.PULSE_CYC(prc_pkg::PULSE_CYC)) u_port_pulse (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(port_start),
        .o_active(port_active)
    ); // [R14]

    // start-up sequencer: tristate, strap latch, oscillator, PLL, release
    logic [31:0] cnt_reg, cnt_next;
    logic from_hw_reg, from_hw_next;
    logic [STRAP_W-1:0] strap_reg, strap_next;
    logic ind_a_reg, ind_a_next, ind_b_reg, ind_b_next;
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 32'h1;
        from_hw_next = from_hw_reg;
        strap_next = strap_reg;
        ind_a_next = ind_a_reg;
        ind_b_next = ind_b_reg;
        case (state_reg)
            prc_pkg::ST_HWRST: begin
                cnt_next = '0;
                from_hw_next = 1'b1;
                state_next = prc_pkg::ST_TRIST;
            end
            prc_pkg::ST_TRIST: begin
                if (cnt_reg == 32'(prc_pkg::TRISTATE_CYC - 1)) begin // [R6]
                    state_next = prc_pkg::ST_STRAP;
                    cnt_next = '0;
                end
            end
            prc_pkg::ST_STRAP: begin
                strap_next = sync2_reg[STRAP_W+1:2]; // [R21]
                ind_a_next = sync2_reg[STRAP_W+2]; // [R20]
                ind_b_next = sync2_reg[STRAP_W+3]; // [R20]
                state_next = prc_pkg::ST_OSC;
                cnt_next = '0;
            end
            prc_pkg::ST_OSC: begin
                if (cnt_reg == 32'(XTAL_CYC - 1)) begin // [R7]
                    state_next = prc_pkg::ST_PLL;
                    cnt_next = '0;
                end
            end
            prc_pkg::ST_PLL: begin
                if (cnt_reg == 32'(PLL_CYC - 1)) begin // [R8] [R10]
                    state_next = prc_pkg::ST_RUN;
                    cnt_next = '0;
                end
            end
            prc_pkg::ST_RUN: begin
                cnt_next = '0;
                if (chip_rst_wr) begin // [R9]
                    state_next = prc_pkg::ST_TRIST;
                    from_hw_next = 1'b0;
                end
            end
            default: state_next = prc_pkg::ST_HWRST;
        endcase
        // hardware reset overrides every step, including a soft sequence in flight
        if (hw_req) begin // [R2] [R3]
            state_next = prc_pkg::ST_HWRST;
            cnt_next = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= prc_pkg::ST_HWRST;
            cnt_reg <= '0;
            from_hw_reg <= 1'b1;
            strap_reg <= '0;
            ind_a_reg <= 1'b0;
            ind_b_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            from_hw_reg <= from_hw_next;
            strap_reg <= strap_next;
            ind_a_reg <= ind_a_next;
            ind_b_reg <= ind_b_next;
        end
    end

    // masks and sticky flags; masks survive core and port resets, not full resets
    logic [15:0] sys_mask_reg, sys_mask_next, core_mask_reg, core_mask_next;
    logic [15:0] core_flags_reg, core_flags_next;
    logic hwrst_flag_reg, hwrst_flag_next, full_rst, irq_any;
    assign full_rst = state_reg == prc_pkg::ST_HWRST || chip_rst_wr;
    always_comb begin
        sys_mask_next = sys_mask_reg;
        core_mask_next = core_mask_reg;
        core_flags_next = core_flags_reg;
        hwrst_flag_next = hwrst_flag_reg;
        if (wr_hit && i_reg_addr == prc_pkg::OFS_SYS_IRQ_MASK) begin
            sys_mask_next = i_reg_wdata;
        end
        if (wr_hit && i_reg_addr == prc_pkg::OFS_CORE_IRQ_MASK) begin
            core_mask_next = i_reg_wdata;
        end
        // reading the core flag register clears it, reading the system one clears only its hardware reset bit; a same-cycle event still lands
        if (rd_hit && i_reg_addr == prc_pkg::OFS_CORE_IRQ_FLAGS) begin // [R19]
            core_flags_next = '0;
        end
        if (rd_hit && i_reg_addr == prc_pkg::OFS_SYS_IRQ_FLAGS) begin // [R19]
            hwrst_flag_next = 1'b0;
        end
        if (full_rst) begin
            sys_mask_next = prc_pkg::SYS_MASK_RST;
            core_mask_next = prc_pkg::CORE_MASK_RST;
            core_flags_next = '0;
        end
        if (i_link_change) begin // [R16]
            core_flags_next[prc_pkg::CORE_LINK_BIT] = 1'b1;
        end
        if (i_fifo_error) begin // [R16]
            core_flags_next[prc_pkg::CORE_FIFO_BIT] = 1'b1;
        end
        if (state_reg == prc_pkg::ST_PLL && state_next == prc_pkg::ST_RUN && from_hw_reg) begin
            hwrst_flag_next = 1'b1; // [R17]
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sys_mask_reg <= prc_pkg::SYS_MASK_RST;
            core_mask_reg <= prc_pkg::CORE_MASK_RST;
            core_flags_reg <= '0;
            hwrst_flag_reg <= 1'b0;
        end else begin
            sys_mask_reg <= sys_mask_next;
            core_mask_reg <= core_mask_next;
            core_flags_reg <= core_flags_next;
            hwrst_flag_reg <= hwrst_flag_next;
        end
    end

    // core causes pass the core mask and then the system-level core enable
    assign irq_any = hwrst_flag_reg
        || (|(core_flags_reg & core_mask_reg) && sys_mask_reg[prc_pkg::SYS_CORE_BIT]); // [R18]

    // read mux; request bits show only a reset still in progress
    logic [15:0] rdata_val;
    always_comb begin
        rdata_val = 16'h0000;
        if (rd_hit) begin
            case (i_reg_addr)
                prc_pkg::OFS_CHIP_RST: rdata_val = 16'h0000; // [R23]
                prc_pkg::OFS_CORE_RST: rdata_val = {15'h0000, core_active}; // [R23]
                prc_pkg::OFS_PORT_RST: rdata_val = {15'h0000, port_active}; // [R23]
                prc_pkg::OFS_SYS_STATE: rdata_val = 16'h0001; // [R11]
                prc_pkg::OFS_SYS_IRQ_MASK: rdata_val = sys_mask_reg;
                prc_pkg::OFS_CORE_IRQ_MASK: rdata_val = core_mask_reg;
                prc_pkg::OFS_SYS_IRQ_FLAGS:
                    rdata_val = {14'h0000, |core_flags_reg, hwrst_flag_reg};
                prc_pkg::OFS_CORE_IRQ_FLAGS: rdata_val = core_flags_reg;
                default: rdata_val = 16'h0000;
            endcase
        end
    end

    // registered outputs
    logic core_rst_next, port_rst_next, run_next, funct_next, osc_next, pll_next;
    logic [MAC_W-1:0] mac_next;
    assign run_next = state_next == prc_pkg::ST_RUN;
    assign funct_next = state_next == prc_pkg::ST_OSC || state_next == prc_pkg::ST_PLL
        || run_next; // [R6]
    assign osc_next = funct_next; // [R7]
    assign pll_next = state_next == prc_pkg::ST_PLL || run_next; // [R7]
    assign core_rst_next = core_active || !run_next; // [R12] [R13]
    assign port_rst_next = port_active || !run_next; // [R15]
    assign mac_next = (core_rst_next || port_rst_next) ? '0 : i_mac_out; // [R1] [R15]

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
            o_mac_out <= '0;
            o_io_functional <= 1'b0;
            o_osc_en <= 1'b0;
            o_pll_en <= 1'b0;
            o_logic_rst <= 1'b1;
            o_core_rst <= 1'b1;
            o_host_port_rst <= 1'b1;
            o_system_ready <= 1'b0;
            o_strap_latched <= '0;
            o_ind_a_active_low <= 1'b0;
            o_ind_b_active_low <= 1'b0;
            o_int_n <= 1'b1;
        end else begin
            o_reg_rdata <= rdata_val;
            o_reg_rvalid <= i_reg_rd;
            o_mac_out <= mac_next;
            o_io_functional <= funct_next;
            o_osc_en <= osc_next;
            o_pll_en <= pll_next;
            o_logic_rst <= !run_next; // [R8]
            o_core_rst <= core_rst_next;
            o_host_port_rst <= port_rst_next;
            o_system_ready <= run_next; // [R11] [R22]
            o_strap_latched <= strap_next;
            o_ind_a_active_low <= ind_a_next;
            o_ind_b_active_low <= ind_b_next;
            o_int_n <= !irq_any; // [R16]
        end
    end

    // helper: cycles spent between leaving reset and releasing logic
    logic [31:0] rel_cnt_reg;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rel_cnt_reg <= '0;
        end else if (state_reg == prc_pkg::ST_HWRST || state_reg == prc_pkg::ST_RUN) begin
            rel_cnt_reg <= '0;
        end else begin
            rel_cnt_reg <= rel_cnt_reg + 32'h1;
        end
    end

    mac_low_a: assert property ( // [R1]
        @(posedge i_clk) disable iff (i_sys_rst) o_core_rst |-> (o_mac_out == '0))
        else $error("MAC outputs not low during core reset");
    power_hold_a: assert property ( // [R3]
        @(posedge i_clk) disable iff (i_sys_rst) !pg_s |=> (state_reg == prc_pkg::ST_HWRST))
        else $error("bad supply did not force hardware reset");
    strap_order_a: assert property ( // [R6]
        @(posedge i_clk) disable iff (i_sys_rst)
        $rose(o_io_functional) |-> ($past(state_reg) == prc_pkg::ST_STRAP))
        else $error("pins went functional before the strap latch");
    pll_after_osc_a: assert property ( // [R7]
        @(posedge i_clk) disable iff (i_sys_rst) $rose(o_pll_en) |-> o_osc_en && $past(o_osc_en))
        else $error("PLL enabled without a running oscillator");
    hw_release_a: assert property ( // [R8]
        @(posedge i_clk) disable iff (i_sys_rst) rel_cnt_reg < 32'(HW_RELEASE_CYC))
        else $error("logic release later than the hardware window");
    sw_release_a: assert property ( // [R10]
        @(posedge i_clk) disable iff (i_sys_rst) !from_hw_reg |-> rel_cnt_reg < 32'(SW_RELEASE_CYC))
        else $error("logic release later than the soft reset window");
    ready_clear_a: assert property ( // [R22]
        @(posedge i_clk) disable iff (i_sys_rst) chip_rst_wr |=> !o_system_ready [*3])
        else $error("ready flag stayed set after a chip reset request");
    nonmask_irq_a: assert property ( // [R17]
        @(posedge i_clk) disable iff (i_sys_rst) hwrst_flag_reg |=> !o_int_n)
        else $error("hardware reset interrupt was suppressed");
    mask_gate_a: assert property ( // [R18]
        @(posedge i_clk) disable iff (i_sys_rst)
        (!hwrst_flag_reg && !sys_mask_reg[prc_pkg::SYS_CORE_BIT]) |=> o_int_n)
        else $error("masked cause reached the interrupt pin");
    regs_kept_a: assert property ( // [R13]
        @(posedge i_clk) disable iff (i_sys_rst)
        (core_active && !full_rst && !wr_hit) |=> $stable(core_mask_reg))
        else $error("core reset disturbed register contents");
endmodule // prc_top

// file: verification/prc_host_model.sv
`timescale 1ns/1ps
// host side: drives the management port, the reset pin and the supply monitor
module prc_host_model (
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic [15:0] i_rdata,
    output logic o_pin_n,
    output logic o_pgood,
    output logic [4:0] o_dev,
    output logic [15:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        {o_pin_n, o_pgood, o_wr, o_rd} = 4'h0;
        {o_dev, o_addr, o_wdata} = 37'h0;
    end
    // pin held low for n cycles, then released
    task automatic pin_low(input int n);
        o_pin_n <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_pin_n <= 1'b1;
    endtask
    // low for 1300 cycles, just past 10 us, while the supply is good
    task automatic power_up();
        o_pgood <= 1'b1;
        pin_low(1300);
    endtask
    // released port lines flip so no stale address is seen
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_dev <= prc_pkg::DEV_ADDR;
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] q, output logic v);
        @(posedge i_clk);
        o_dev <= prc_pkg::DEV_ADDR;
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        q = i_rdata;
        v = i_rvalid;
    endtask
endmodule // prc_host_model

// file: verification/tb.sv
`timescale 1ns/1ps
// bench for reset sequencing, soft resets and interrupt gating
module tb;
    logic clk, rst, pin_n, pgood, wr, rd, rvalid, link, fifo, crst, ready, int_n, lrst, v;
    logic [4:0] dev;
    logic [15:0] addr, wdata, rdata, q;
    logic [7:0] mac_in, mac_out;
    logic [5:0] strap, slat;
    logic ind_a, ind_b, ia_lo, ib_lo, prst;
    int err_count;
    int comparisons;
    localparam logic [15:0] SM [4] = '{16'h0002, 16'h0002, 16'h0000, 16'h0002};
    localparam logic [15:0] CM [4] = '{16'h0001, 16'h0002, 16'h0003, 16'h0001};
    localparam logic [1:0] EV [4] = '{2'b10, 2'b01, 2'b10, 2'b01};
    localparam logic EXP [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    prc_host_model prc_host_model_i (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_pin_n(pin_n), .o_pgood(pgood), .o_dev(dev), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    prc_top #(.XTAL_CYC(20), .PLL_CYC(10), .HW_RELEASE_CYC(400), .SW_RELEASE_CYC(300)) prc_top_i (
        .i_clk(clk), .i_sys_rst(rst), .i_reset_pin_n(pin_n), .i_power_good(pgood),
        .i_strap(strap), .i_ind_a_sense(ind_a), .i_ind_b_sense(ind_b), .i_mac_out(mac_in),
        .i_link_change(link), .i_fifo_error(fifo), .i_reg_dev(dev), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_mac_out(mac_out), .o_io_functional(), .o_osc_en(),
        .o_pll_en(), .o_logic_rst(lrst), .o_core_rst(crst), .o_host_port_rst(prst),
        .o_system_ready(ready), .o_strap_latched(slat), .o_ind_a_active_low(ia_lo),
        .o_ind_b_active_low(ib_lo), .o_int_n(int_n));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [15:0] a, input logic [15:0] e);
        prc_host_model_i.rd(a, q, v);
        chk("rvalid", 16'h0001, {15'h0, v});
        chk("rdata", e, q);
    endtask
    // bounded wait; the budget sits above the whole start-up sequence
    task automatic wait_ready();
        for (int i = 0; i < 500 && ready !== 1'b1; i++) @(posedge clk);
        #1;
    endtask
    task automatic final_report();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // tests need a few thousand cycles; this cuts a hang short
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    initial begin
        {rst, link, fifo} = 3'b100;
        {mac_in, strap, ind_a, ind_b} = 16'hA5B6;
        err_count = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        prc_host_model_i.power_up();
        chk("ready", 16'h0, {15'h0, ready});
        wait_ready();
        chk("ready", 16'h1, {15'h0, ready});
        chk("logic_rst", 16'h0, {15'h0, lrst});
        chk("int_n", 16'h0, {15'h0, int_n});
        chk("pins", 16'hA56D, {mac_out, ib_lo, ia_lo, slat});
        rchk(prc_pkg::OFS_SYS_IRQ_FLAGS, 16'h0001);
        prc_host_model_i.pin_low(60);
        repeat (140) @(posedge clk);
        #1;
        chk("ready", 16'h1, {15'h0, ready});
        chk("int_n", 16'h1, {15'h0, int_n});
        $display("test boot done");
        prc_host_model_i.wr(prc_pkg::OFS_CORE_RST, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        chk("core_rst", 16'h1, {15'h0, crst});
        chk("mac_out", 16'h0, {8'h0, mac_out});
        rchk(prc_pkg::OFS_CORE_RST, 16'h0001);
        repeat (150) @(posedge clk);
        rchk(prc_pkg::OFS_CORE_RST, 16'h0000);
        chk("mac_out", 16'h00A5, {8'h0, mac_out});
        $display("test core reset done");
        for (int k = 0; k < 4; k++) begin
            prc_host_model_i.wr(prc_pkg::OFS_SYS_IRQ_MASK, SM[k]);
            prc_host_model_i.wr(prc_pkg::OFS_CORE_IRQ_MASK, CM[k]);
            @(posedge clk);
            {link, fifo} <= EV[k];
            @(posedge clk);
            {link, fifo} <= 2'b00;
            @(posedge clk);
            #1;
            chk("int_n", {15'h0, EXP[k]}, {15'h0, int_n});
            rchk(prc_pkg::OFS_CORE_IRQ_FLAGS, {14'h0, EV[k][0], EV[k][1]});
        end
        $display("test interrupt done");
        prc_host_model_i.wr(prc_pkg::OFS_PORT_RST, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        chk("port", 16'h0100, {7'h0, prst, mac_out});
        rchk(prc_pkg::OFS_CORE_IRQ_MASK, 16'h0001);
        $display("test port reset done");
        prc_host_model_i.wr(prc_pkg::OFS_CHIP_RST, 16'h0001);
        {mac_in, strap, ind_a, ind_b} <= 16'h3C49;
        @(posedge clk);
        #1;
        chk("ready", 16'h0, {15'h0, ready});
        chk("logic_rst", 16'h1, {15'h0, lrst});
        wait_ready();
        chk("ready", 16'h1, {15'h0, ready});
        chk("pins", 16'h3C92, {mac_out, ib_lo, ia_lo, slat});
        rchk(prc_pkg::OFS_CHIP_RST, 16'h0000);
        rchk(prc_pkg::OFS_SYS_IRQ_MASK, 16'h0000);
        rchk(prc_pkg::OFS_SYS_STATE, 16'h0001);
        rchk(16'h9000, 16'h0000);
        $display("test chip reset done");
        final_report();
    end
endmodule // tb
